// >>> pkg/dis_pkg.sv
// Package for the dual-input load switch control state machine
package dis_pkg;

  // Clock rate and chosen timing figures (microseconds)
  localparam int CLK_MHZ = 10;
  localparam int T_INIT_US = 1000;
  localparam int T_DIS_US = 1000;
  localparam int T_DEB_USB_US = 100;
  localparam int T_DEB_OUT_US = 100;
  localparam int T_EN_LOW_US = 50;
  localparam int T_EN_HIGH_US = 50;
  localparam int T_FLAG_LOW_US = 50;
  localparam int T_FLAG_HIGH_US = 50;
  localparam int T_FALL_US = 0;

  // Debouncer channels and their settle counts in clock cycles
  localparam int NUM_DEB = 4;
  localparam int CH_USB = 0;
  localparam int CH_OUT = 1;
  localparam int CH_EN_N = 2;
  localparam int CH_FLAG_N = 3;
  localparam int DEB_W = 16;
  typedef logic [DEB_W-1:0] dis_cnt_t;
  localparam dis_cnt_t DEB_RISE [NUM_DEB] = '{
    dis_cnt_t'(T_DEB_USB_US * CLK_MHZ), dis_cnt_t'(T_DEB_OUT_US * CLK_MHZ),
    dis_cnt_t'(T_EN_HIGH_US * CLK_MHZ), dis_cnt_t'(T_FLAG_HIGH_US * CLK_MHZ)};
  localparam dis_cnt_t DEB_FALL [NUM_DEB] = '{
    dis_cnt_t'(T_FALL_US * CLK_MHZ + 1), dis_cnt_t'(T_FALL_US * CLK_MHZ + 1),
    dis_cnt_t'(T_EN_LOW_US * CLK_MHZ), dis_cnt_t'(T_FLAG_LOW_US * CLK_MHZ)};
  localparam int TMR_W = 24;

  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_RECOVER_BIT = 0;
  localparam logic CTRL_RECOVER_RST = 1'b1;

  // Control states
  typedef enum logic [3:0] {
    ST_OFF, ST_INIT, ST_AUTO_READY, ST_AUTONOMOUS_DISCHARGE_STATE, ST_AUTO_ON, ST_OTG_READY,
    ST_OTG_ON, ST_REVERSE_DISCHARGE_STATE, ST_AUTO_TSD, ST_SLAVE_READY, ST_SLAVE_OTG_READY,
    ST_SLAVE_ON, ST_SLAVE_TSD
  } dis_state_t;

  // Pin-facing drive set for one state
  typedef struct packed {
    logic sw_close;
    logic disch;
    logic rx_n;
    logic flag_release;
  } dis_drive_t;

  // Status word layout, low bits of STATUS
  typedef struct packed {
    logic auto_mode;
    logic vout_valid;
    logic vbus_valid;
    dis_drive_t drive;
    dis_state_t state;
  } dis_status_t;

endpackage

// >>> core/dis_ctrl.sv
// Control state machine of the dual-input bidirectional load switch
// Summary of operation
// - Unpowered: no actions; init: switch open, receiver output and handshake low.
// - Init lasts the init duration before the mode is decided.
// - Autonomous detected at init end: enter auto-ready, all outputs low, switch open.
// - Auto-discharge returns to auto-ready when input supply stops being valid.
// - Valid input in autonomous: switch open, receiver high, discharge both terminals.
// - Leave discharge for auto-on only after output rail below threshold and timer.
// - Auto-on and slave-on: switch closed, receiver high, handshake low.
// - Valid output in autonomous: OTG-ready, switch open, receiver low, handshake released.
// - Handshake forced low in OTG-ready: OTG-on, switch closed, receiver high.
// - Handshake released in OTG-on: open, discharge for duration, back to OTG-ready.
// - Slave detected at init end: slave-ready, switch open, outputs low.
// - Slave-ready from autonomous states only if enable was low at init end.
// - Valid output in slave: slave-OTG-ready, switch open, receiver low, handshake high.
// - Enable high in autonomous states moves to slave-ready.
// - Under that exit, OTG-ready maps to slave-OTG-ready.
// - Over-temperature in slave states: slave shutdown, open, receiver high, handshake low.
// - Over-temperature in autonomous states: auto shutdown, same drive pattern.
// - Temperature back below threshold lets shutdown states recover.
// - Overvoltage opens the switch asynchronously, state machine untouched.
// - Valid input: input rail above threshold for input debounce time.
// - Valid output: output rail above threshold debounced, no valid input.
// - OTG enable: handshake low while released, held for debounce time.
`timescale 1ns/1ps
`default_nettype none

module dis_ctrl
  import dis_pkg::*;
#(
  parameter int INIT_CYC = T_INIT_US * CLK_MHZ,
  parameter int DIS_CYC = T_DIS_US * CLK_MHZ
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Analog comparator and pin inputs (asynchronous)
  input wire logic input_port_rail_ok_i,
  input wire logic output_rail_ok_i,
  input wire logic over_temp_i,
  input wire logic over_voltage_i,
  input wire logic enable_n_i,
  // Handshake pin, open drain
  input wire logic flag_n_i,
  output logic flag_n_o,
  output logic flag_n_oe_o,
  // Power path and receiver control
  output logic switch_close_o,
  output logic disch_input_o,
  output logic disch_output_o,
  output logic rx_n_o,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and debouncers
  logic [NUM_DEB-1:0] raw_pins;
  logic [NUM_DEB-1:0] sync1_r;
  logic [NUM_DEB-1:0] sync2_r;
  logic [NUM_DEB-1:0] deb_in;
  logic [NUM_DEB-1:0] deb_r;
  logic temp1_r;
  logic temp2_r;
  assign raw_pins = {flag_n_i, enable_n_i, output_rail_ok_i, input_port_rail_ok_i};
  // Two flops on every asynchronous input except overvoltage, which acts on the switch unsynchronised
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      temp1_r <= 1'b0;
      temp2_r <= 1'b0;
    end else begin
      sync1_r <= raw_pins;
      sync2_r <= sync1_r;
      temp1_r <= over_temp_i;
      temp2_r <= temp1_r;
    end
  end
  // Wire counts as high while we pull it, so OTG enable needs the system's own pull
  assign deb_in = sync2_r | (NUM_DEB'(flag_n_oe_o) << CH_FLAG_N);
  // Per-channel debouncer: level follows input once stable for its count
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DEB; gi++) begin : g_deb
      dis_cnt_t cnt_r;
      dis_cnt_t limit;
      logic differs;
      logic settled;
      assign differs = deb_in[gi] != deb_r[gi];
      assign limit = deb_in[gi] ? DEB_RISE[gi] : DEB_FALL[gi];
      assign settled = differs && (cnt_r + dis_cnt_t'(1) >= limit);
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cnt_r <= '0;
          deb_r[gi] <= 1'b0;
        end else begin
          cnt_r <= (differs && !settled) ? cnt_r + dis_cnt_t'(1) : '0;
          deb_r[gi] <= settled ? deb_in[gi] : deb_r[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Qualified conditions
  logic power_up;
  logic vbus_valid;
  logic vout_valid;
  logic vout_discharged;
  logic en_active;
  logic en_inactive;
  logic otg_enable;
  logic otg_disable;
  logic in_temp;
  // Either raw rail above threshold keeps the core alive
  assign power_up = sync2_r[CH_USB] | sync2_r[CH_OUT];
  assign vbus_valid = deb_r[CH_USB];
  assign vout_valid = deb_r[CH_OUT] & ~deb_r[CH_USB];
  // Safety check on the raw level: no debounce delays the discharge exit
  assign vout_discharged = ~sync2_r[CH_OUT];
  assign en_active = ~deb_r[CH_EN_N];
  assign en_inactive = deb_r[CH_EN_N];
  // Pin is only looked at while this block leaves it released
  assign otg_enable = ~deb_r[CH_FLAG_N];
  assign otg_disable = deb_r[CH_FLAG_N];
  assign in_temp = ~temp2_r;

  ////////////////////////////////////////////////////////////////////////////
  // State machine
  dis_state_t state_r;
  dis_state_t state_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic auto_at_init_r;
  logic auto_at_init_nxt;
  logic recover_en_r;
  logic init_done;
  logic dis_done;
  logic is_auto;
  logic is_slave;
  assign init_done = tmr_r >= TMR_W'(INIT_CYC - 1);
  assign dis_done = tmr_r >= TMR_W'(DIS_CYC - 1);
  assign is_auto = state_r inside {ST_AUTO_READY, ST_AUTONOMOUS_DISCHARGE_STATE, ST_AUTO_ON,
                                   ST_OTG_READY, ST_OTG_ON, ST_REVERSE_DISCHARGE_STATE};
  assign is_slave = state_r inside {ST_SLAVE_READY, ST_SLAVE_OTG_READY, ST_SLAVE_ON};
  // Mode caught as init ends; used to gate the autonomous exit path
  assign auto_at_init_nxt = (state_r == ST_INIT && init_done) ? en_active : auto_at_init_r;
  // Next-state decision; power loss and thermal events take priority
  always_comb begin
    state_nxt = state_r;
    if (!power_up) begin
      state_nxt = ST_OFF;
    end else if (temp2_r && is_slave) begin
      state_nxt = ST_SLAVE_TSD;
    end else if (temp2_r && is_auto) begin
      state_nxt = ST_AUTO_TSD;
    end else if (is_auto && en_inactive && auto_at_init_r) begin
      // Exit from autonomous operation to a slave state
      state_nxt = (state_r == ST_OTG_READY) ? ST_SLAVE_OTG_READY : ST_SLAVE_READY;
    end else begin
      unique case (state_r)
        ST_OFF: begin
          state_nxt = ST_INIT;
        end
        ST_INIT: begin
          if (init_done) begin
            state_nxt = en_active ? ST_AUTO_READY : ST_SLAVE_READY;
          end
        end
        ST_AUTO_READY: begin
          if (vbus_valid) begin
            state_nxt = ST_AUTONOMOUS_DISCHARGE_STATE;
          end else if (vout_valid) begin
            state_nxt = ST_OTG_READY;
          end
        end
        ST_AUTONOMOUS_DISCHARGE_STATE: begin
          if (!vbus_valid) begin
            state_nxt = ST_AUTO_READY;
          end else if (dis_done && vout_discharged) begin
            state_nxt = ST_AUTO_ON;
          end
        end
        ST_AUTO_ON: begin
          state_nxt = ST_AUTO_ON;
        end
        ST_OTG_READY: begin
          if (!vout_valid) begin
            state_nxt = ST_AUTO_READY;
          end else if (otg_enable) begin
            state_nxt = ST_OTG_ON;
          end
        end
        ST_OTG_ON: begin
          if (otg_disable) begin
            state_nxt = ST_REVERSE_DISCHARGE_STATE;
          end
        end
        ST_REVERSE_DISCHARGE_STATE: begin
          if (dis_done) begin
            state_nxt = ST_OTG_READY;
          end
        end
        ST_SLAVE_READY: begin
          if (en_active) begin
            state_nxt = ST_SLAVE_ON;
          end else if (vout_valid) begin
            state_nxt = ST_SLAVE_OTG_READY;
          end
        end
        ST_SLAVE_OTG_READY: begin
          if (en_active) begin
            state_nxt = ST_SLAVE_ON;
          end else if (!vout_valid) begin
            state_nxt = ST_SLAVE_READY;
          end
        end
        ST_SLAVE_ON: begin
          if (en_inactive) begin
            state_nxt = ST_SLAVE_READY;
          end
        end
        ST_AUTO_TSD: begin
          if (in_temp && recover_en_r) begin
            state_nxt = ST_AUTO_READY;
          end
        end
        ST_SLAVE_TSD: begin
          if (in_temp && recover_en_r) begin
            state_nxt = ST_SLAVE_READY;
          end
        end
        default: begin
          state_nxt = ST_OFF;
        end
      endcase
    end
  end

  // State, dwell timer and captured mode
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_OFF;
      tmr_r <= '0;
      auto_at_init_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= (state_nxt != state_r) ? '0 : tmr_r + TMR_W'(1);
      auto_at_init_r <= auto_at_init_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive decode
  dis_drive_t drv_nxt;
  // Drive pattern of the state being entered; unpowered drives nothing
  always_comb begin
    drv_nxt = '{sw_close: 1'b0, disch: 1'b0, rx_n: 1'b0, flag_release: 1'b0};
    unique case (state_nxt)
      ST_OFF, ST_INIT, ST_AUTO_READY, ST_SLAVE_READY: begin
        drv_nxt.rx_n = 1'b0;
      end
      ST_AUTONOMOUS_DISCHARGE_STATE: begin
        drv_nxt.rx_n = 1'b1;
        drv_nxt.disch = 1'b1;
      end
      ST_AUTO_ON, ST_SLAVE_ON, ST_OTG_ON: begin
        drv_nxt.sw_close = 1'b1;
        drv_nxt.rx_n = 1'b1;
        drv_nxt.flag_release = (state_nxt == ST_OTG_ON);
      end
      ST_OTG_READY, ST_SLAVE_OTG_READY: begin
        drv_nxt.flag_release = 1'b1;
      end
      ST_REVERSE_DISCHARGE_STATE: begin
        drv_nxt.rx_n = 1'b1;
        drv_nxt.disch = 1'b1;
        drv_nxt.flag_release = 1'b1;
      end
      ST_AUTO_TSD, ST_SLAVE_TSD: begin
        drv_nxt.rx_n = 1'b1;
      end
      default: begin
        drv_nxt.rx_n = 1'b0;
      end
    endcase
  end
  // Output flops; overvoltage clears the switch at once, without a clock
  always_ff @(posedge ref_clk_i or negedge resetn_i or posedge over_voltage_i) begin
    if (!resetn_i) begin
      switch_close_o <= 1'b0;
    end else if (over_voltage_i) begin
      switch_close_o <= 1'b0;
    end else begin
      switch_close_o <= drv_nxt.sw_close;
    end
  end
  // Remaining pin outputs
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      disch_input_o <= 1'b0;
      disch_output_o <= 1'b0;
      rx_n_o <= 1'b0;
      flag_n_oe_o <= 1'b0;
      flag_n_o <= 1'b0;
    end else begin
      disch_input_o <= drv_nxt.disch;
      disch_output_o <= drv_nxt.disch;
      rx_n_o <= drv_nxt.rx_n;
      // Open drain: only ever pulls low, in unpowered state it lets go
      flag_n_oe_o <= ~drv_nxt.flag_release & (state_nxt != ST_OFF);
      flag_n_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register slave
  logic setup_ph;
  logic wr_go;
  logic hit_ctrl;
  logic hit_status;
  logic unmapped;
  dis_status_t status;
  logic [31:0] rd_mux;
  // One wait-free access: pready rises in the first access cycle
  assign setup_ph = psel_i & ~penable_i;
  assign wr_go = psel_i & penable_i & pready_o & pwrite_i;
  assign hit_ctrl = paddr_i == ADDR_CTRL;
  assign hit_status = paddr_i == ADDR_STATUS;
  assign unmapped = ~(hit_ctrl | hit_status);
  assign status = '{auto_mode: auto_at_init_r, vout_valid: vout_valid,
                    vbus_valid: vbus_valid, drive: drv_nxt, state: state_r};
  assign rd_mux = hit_ctrl ? {31'h0, recover_en_r} :
                  hit_status ? 32'(status) : 32'h0000_0000;
  // Bus answer flops
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= setup_ph;
      pslverr_o <= setup_ph & unmapped;
      prdata_o <= (setup_ph && !pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // Control register: lets the thermal states recover when set
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      recover_en_r <= CTRL_RECOVER_RST;
    end else if (wr_go && hit_ctrl) begin
      recover_en_r <= pwdata_i[CTRL_RECOVER_BIT];
    end
  end

endmodule

`default_nettype wire

// >>> dv/dis_ctrl_properties.sv
// Port checker for the load switch control state machine
`timescale 1ns/1ps
`default_nettype none
module dis_ctrl_chk #(
  parameter int INIT_CYC = 20,
  parameter int DIS_CYC = 20
) (
  // Clock, reset and watched inputs
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic over_temp_i,
  input wire logic over_voltage_i,
  input wire logic flag_n_i,
  // Watched drives
  input wire logic flag_n_oe_o,
  input wire logic switch_close_o,
  input wire logic disch_input_o,
  input wire logic disch_output_o,
  input wire logic rx_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////
  // Discharge run length and time since reset; only time since reset saturates, so it never wraps
  logic [15:0] dis_cnt_r;
  logic [15:0] up_cnt_r;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dis_cnt_r <= 16'h0;
      up_cnt_r <= 16'h0;
    end else begin
      dis_cnt_r <= disch_input_o ? dis_cnt_r + 16'h1 : 16'h0;
      up_cnt_r <= (up_cnt_r == 16'hFFFF) ? up_cnt_r : up_cnt_r + 16'h1;
    end
  end
  ////////////////////////////////////////
  // Power path relations
  a_init_idle: assert property (up_cnt_r < 16'(INIT_CYC) |-> !switch_close_o && !rx_n_o)
    else $error("switch or receiver active before init ended");
  a_ov_open: assert property (over_voltage_i && $past(over_voltage_i) |-> !switch_close_o)
    else $error("switch closed during overvoltage");
  a_sw_rx: assert property (switch_close_o |-> rx_n_o)
    else $error("switch closed with receiver enabled");
  a_disch_pair: assert property (disch_input_o == disch_output_o)
    else $error("discharge loads differ");
  a_disch_safe: assert property (disch_input_o |-> rx_n_o && !switch_close_o)
    else $error("discharge with switch closed or receiver on");
  a_disch_min: assert property ($fell(disch_input_o) && switch_close_o |-> dis_cnt_r >= 16'(DIS_CYC))
    else $error("discharge shorter than minimum");
  a_temp_open: assert property (over_temp_i [*6] |-> !switch_close_o)
    else $error("switch closed while hot");
  a_otg_pull: assert property ($rose(switch_close_o) && !flag_n_oe_o |-> !flag_n_i)
    else $error("reverse switch on without system pull");
endmodule
`default_nettype wire

// >>> dv/dis_sys_model.sv
// System-side model of the open-drain handshake wire
`timescale 1ns/1ps
`default_nettype none
module dis_sys_model (
  // Device drive and system command
  input wire logic flag_n_o,
  input wire logic flag_n_oe_o,
  input wire logic pull_low_i,
  // Resolved wire
  output logic flag_wire_o
);
  // On-chip pull-up; whichever party pulls low wins the wire
  assign flag_wire_o = ((flag_n_oe_o && !flag_n_o) || pull_low_i) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the load switch control state machine
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dis_pkg::*;
  localparam int INIT_CYC = 20;
  localparam int DIS_CYC = 20;
  // Stimulus, all driven at the rising edge
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic in_ok = 1'b0;
  logic out_ok = 1'b0;
  logic hot = 1'b0;
  logic ov = 1'b0;
  logic en_n = 1'b0;
  logic sys_pull = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  // Observed
  logic [31:0] prdata;
  logic pready, pslverr, flag_wire, flag_n, flag_oe, sw, dis_in, dis_out, rx_n;
  int bad_count = 0;
  int num_checks = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  dis_ctrl #(.INIT_CYC(INIT_CYC), .DIS_CYC(DIS_CYC)) DUT (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .input_port_rail_ok_i(in_ok),
    .output_rail_ok_i(out_ok), .over_temp_i(hot), .over_voltage_i(ov), .enable_n_i(en_n),
    .flag_n_i(flag_wire), .flag_n_o(flag_n), .flag_n_oe_o(flag_oe), .switch_close_o(sw),
    .disch_input_o(dis_in), .disch_output_o(dis_out), .rx_n_o(rx_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  dis_sys_model u_sys (.flag_n_o(flag_n), .flag_n_oe_o(flag_oe), .pull_low_i(sys_pull),
    .flag_wire_o(flag_wire));
  ////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", {31'h0, pready}, 32'h1);
    if (pready !== 1'b1) results();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  // Poll the state field, bounded; outputs change on the same edge as the state
  task automatic go(input dis_state_t s);
    logic [31:0] d;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0, d, e);
      n++;
    end while (d[3:0] !== s && n < 4000);
    chk("state", {28'h0, d[3:0]}, {28'h0, s});
    if (d[3:0] !== s) results();
    repeat (2) @(posedge ref_clk_i);
  endtask
  // Expected drive as {switch, rx_n, flag driven, discharge}
  task automatic outs(input logic [3:0] e);
    chk("drive", {28'h0, sw, rx_n, flag_oe, dis_in}, {28'h0, e});
    chk("disch_out", {31'h0, dis_out}, {31'h0, e[0]});
    chk("flag value", {31'h0, flag_n}, 32'h0);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic e;
    chk("idle drive", {30'h0, sw, rx_n}, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0, d, e);
    chk("ctrl reset", d, {31'h0, CTRL_RECOVER_RST});
    chk("mapped err", {31'h0, e}, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h0, d, e);
    apb(1'b0, ADDR_CTRL, 32'h0, d, e);
    chk("ctrl write", d, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1, d, e);
    apb(1'b0, 8'h08, 32'h0, d, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", d, 32'h0);
    go(ST_OFF);
    $display("test regs done");
  endtask
  task automatic t_otg();
    in_ok <= 1'b1;
    go(ST_AUTO_READY);
    outs(4'h2);
    go(ST_AUTONOMOUS_DISCHARGE_STATE);
    outs(4'h7);
    out_ok <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    go(ST_AUTONOMOUS_DISCHARGE_STATE);
    in_ok <= 1'b0;
    go(ST_AUTO_READY);
    go(ST_OTG_READY);
    outs(4'h0);
    sys_pull <= 1'b1;
    go(ST_OTG_ON);
    chk("otg drive", {30'h0, sw, rx_n}, 32'h3);
    sys_pull <= 1'b0;
    go(ST_REVERSE_DISCHARGE_STATE);
    outs(4'h5);
    go(ST_OTG_READY);
    en_n <= 1'b1;
    go(ST_SLAVE_OTG_READY);
    outs(4'h0);
    en_n <= 1'b0;
    go(ST_SLAVE_ON);
    outs(4'hE);
    hot <= 1'b1;
    go(ST_SLAVE_TSD);
    outs(4'h6);
    hot <= 1'b0;
    // Enable is still low, so slave-ready moves straight on to slave-on
    go(ST_SLAVE_ON);
    out_ok <= 1'b0;
    go(ST_OFF);
    $display("test otg done");
  endtask
  task automatic t_auto();
    in_ok <= 1'b1;
    go(ST_AUTO_ON);
    outs(4'hE);
    ov <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk("ov switch", {31'h0, sw}, 32'h0);
    go(ST_AUTO_ON);
    ov <= 1'b0;
    hot <= 1'b1;
    go(ST_AUTO_TSD);
    outs(4'h6);
    hot <= 1'b0;
    go(ST_AUTO_ON);
    en_n <= 1'b1;
    go(ST_SLAVE_READY);
    in_ok <= 1'b0;
    go(ST_OFF);
    $display("test auto done");
  endtask
  task automatic t_slave();
    in_ok <= 1'b1;
    go(ST_SLAVE_READY);
    outs(4'h2);
    in_ok <= 1'b0;
    go(ST_OFF);
    $display("test slave done");
  endtask
  ////////////////////////////////////////
  // Settle the handshake debouncer before any rail appears
  initial begin
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (600) @(posedge ref_clk_i);
    t_regs();
    t_otg();
    t_auto();
    t_slave();
    results();
  end
endmodule
bind dis_ctrl dis_ctrl_chk #(.INIT_CYC(INIT_CYC), .DIS_CYC(DIS_CYC)) u_chk (
  .ref_clk_i, .resetn_i, .over_temp_i, .over_voltage_i, .flag_n_i, .flag_n_oe_o,
  .switch_close_o, .disch_input_o, .disch_output_o, .rx_n_o);
`default_nettype wire
